//--- cmp_cfg_map.svh
// offsets, field positions, reset values and step counts of the
// comparator timing and threshold block; definitions only
`ifndef CMP_CFG_MAP_SVH
`define CMP_CFG_MAP_SVH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define MODE_IDX 16'hFD42
`define TIMING_IDX 16'hFD44
`define THRESH_IDX 16'hFD46
`define RESULT_IDX 16'hFD48
`define MODE_ADDR ({14'h0000, `MODE_IDX, 2'h0})
`define TIMING_ADDR ({14'h0000, `TIMING_IDX, 2'h0})
`define THRESH_ADDR ({14'h0000, `THRESH_IDX, 2'h0})
`define RESULT_ADDR ({14'h0000, `RESULT_IDX, 2'h0})

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MODE_RST 2'h0
`define TIMING_RST 8'h37
`define THRESH_RST 6'h00
`define RESULT_RST 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SAMPLE_DELAY_SEL_LSB 0
`define SAMPLE_DELAY_SEL_MSB 2
`define TRIGDIV_LSB 4
`define TRIGDIV_MSB 5
`define THRESH_MSB 5
`define MODE_MSB 1

// ----------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------
`define MODE_BURST 2'h2
`define MODE_LOWPWR 2'h3

// ----------------------------------------------------------------
// settling and compare periods in core cycles per delay code
// ----------------------------------------------------------------
`define SETTLE_0 6'h01
`define SETTLE_1 6'h01
`define SETTLE_2 6'h02
`define SETTLE_3 6'h02
`define SETTLE_4 6'h02
`define SETTLE_5 6'h02
`define SETTLE_6 6'h03
`define SETTLE_7 6'h03
`define COMPARE_0 6'h0A
`define COMPARE_1 6'h0F
`define COMPARE_2 6'h14
`define COMPARE_3 6'h19
`define COMPARE_4 6'h1E
`define COMPARE_5 6'h23
`define COMPARE_6 6'h2D
`define COMPARE_7 6'h37

// ----------------------------------------------------------------
// trigger divide ratio minus one per divider code (8,16,32,64)
// ----------------------------------------------------------------
`define TRIGDIV_0 6'h07
`define TRIGDIV_1 6'h0F
`define TRIGDIV_2 6'h1F
`define TRIGDIV_3 6'h3F

`endif

//--- cmp_cfg_pkg.sv
// types shared by the comparator timing and threshold block
// assumes nothing of its surroundings
package cmp_cfg_pkg;

    typedef struct packed {
        logic [1:0] trigger_divider_sel;
        logic [2:0] sample_delay_sel;
    } timing_sel_t;

    typedef struct packed {
        logic busy;
        logic settling;
        logic done;
    } step_status_t;

    typedef enum logic [1:0] {
        STEP_IDLE,
        STEP_SETTLE,
        STEP_COMPARE
    } step_state_t;

endpackage

//--- compare_step_timer.sv
// one comparison step: settling period then compare period
// assumes start is a one-cycle pulse on sys_clk
`timescale 1ns/1ps
`include "cmp_cfg_map.svh"

module compare_step_timer
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [2:0] sample_delay_sel,
    output cmp_cfg_pkg::step_status_t status
);
    import cmp_cfg_pkg::*;

    step_state_t state_r;
    step_state_t state_nxt;
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic done_r;
    logic done_nxt;
    logic [5:0] settle_len;
    logic [5:0] compare_len;

    // ------------------------------------------------------------
    // period lookup
    // ------------------------------------------------------------
    always_comb
    begin
        case (sample_delay_sel)
            3'h0:
            begin
                settle_len = `SETTLE_0;
                compare_len = `COMPARE_0;
            end
            3'h1:
            begin
                settle_len = `SETTLE_1;
                compare_len = `COMPARE_1;
            end
            3'h2:
            begin
                settle_len = `SETTLE_2;
                compare_len = `COMPARE_2;
            end
            3'h3:
            begin
                settle_len = `SETTLE_3;
                compare_len = `COMPARE_3;
            end
            3'h4:
            begin
                settle_len = `SETTLE_4;
                compare_len = `COMPARE_4;
            end
            3'h5:
            begin
                settle_len = `SETTLE_5;
                compare_len = `COMPARE_5;
            end
            3'h6:
            begin
                settle_len = `SETTLE_6;
                compare_len = `COMPARE_6;
            end
            default:
            begin
                settle_len = `SETTLE_7;
                compare_len = `COMPARE_7;
            end
        endcase
    end

    // ------------------------------------------------------------
    // step sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        case (state_r)
            STEP_IDLE:
            begin
                if (start)
                begin
                    state_nxt = STEP_SETTLE;
                    cnt_nxt = settle_len - 6'h01;
                end
            end
            STEP_SETTLE:
            begin
                if (cnt_r == 6'h00)
                begin
                    state_nxt = STEP_COMPARE;
                    cnt_nxt = compare_len - 6'h01;
                end
                else
                begin
                    cnt_nxt = cnt_r - 6'h01;
                end
            end
            STEP_COMPARE:
            begin
                if (cnt_r == 6'h00)
                begin
                    state_nxt = STEP_IDLE;
                    done_nxt = 1'b1;
                end
                else
                begin
                    cnt_nxt = cnt_r - 6'h01;
                end
            end
            default:
            begin
                state_nxt = STEP_IDLE;
                cnt_nxt = 6'h00;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state_r <= STEP_IDLE;
            cnt_r <= 6'h00;
            done_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign status.busy = (state_r != STEP_IDLE);
    assign status.settling = (state_r == STEP_SETTLE);
    assign status.done = done_r;

endmodule

//--- comparator_timing_threshold_cfg.sv
// comparator timing, trigger division and threshold registers
// assumes a classic wishbone master and asynchronous comparator
// outputs and timer trigger from outside the sys_clk domain
`timescale 1ns/1ps
`include "cmp_cfg_map.svh"

// Contract
// - each step lasts the settling plus compare cycles of the delay code, 7 by default.
// - the trigger divider divides the timer trigger only in low-power mode.
// - the threshold code drives the converter in both threshold modes.
// - all eight inputs are compared against the one threshold voltage.
// - the threshold is a 6-bit unsigned code with bits 7 and 6 reserved.
// - reset clears the whole threshold register to zero.
// - mode 10 is threshold burst, 11 low-power, results valid only there.
// - a result bit reads 0 below threshold and 1 above.
module comparator_timing_threshold_cfg
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic timer_trigger_input,
    input wire logic [7:0] analog_sense_input,
    output logic [5:0] dac_code,
    output logic dac_enable,
    output logic settling
);
    import cmp_cfg_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [1:0] comparator_mode_sel_r;
    logic [1:0] comparator_mode_sel_nxt;
    timing_sel_t timing_r;
    timing_sel_t timing_nxt;
    logic [5:0] threshold_code_r;
    logic [5:0] threshold_code_nxt;
    logic [7:0] compare_result_bit_r;
    logic [7:0] compare_result_bit_nxt;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [2:0] trig_sync_r;
    logic [7:0] sense_s1_r;
    logic [7:0] sense_s2_r;
    logic [5:0] div_cnt_r;
    logic [5:0] div_cnt_nxt;
    logic pending_r;
    logic pending_nxt;
    logic start_r;
    logic start_nxt;
    logic dac_enable_r;
    logic dac_enable_nxt;
    logic settling_r;
    logic settling_nxt;
    logic [5:0] div_last;
    logic trig_edge;
    logic burst_mode;
    logic lowpwr_mode;
    logic wr_en;
    step_status_t step;

    assign burst_mode = (comparator_mode_sel_r == `MODE_BURST);
    assign lowpwr_mode = (comparator_mode_sel_r == `MODE_LOWPWR);
    assign trig_edge = trig_sync_r[1] & ~trig_sync_r[2];
    assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r & wb_sel_i[0];

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            trig_sync_r <= 3'h0;
            sense_s1_r <= 8'h00;
            sense_s2_r <= 8'h00;
        end
        else
        begin
            trig_sync_r <= {trig_sync_r[1:0], timer_trigger_input};
            sense_s1_r <= analog_sense_input;
            sense_s2_r <= sense_s1_r;
        end
    end

    // ------------------------------------------------------------
    // step timer
    // ------------------------------------------------------------
    compare_step_timer i_compare_step_timer
    (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .start(start_r),
        .sample_delay_sel(timing_r.sample_delay_sel),
        .status(step)
    );

    // ------------------------------------------------------------
    // trigger divider and step launch
    // ------------------------------------------------------------
    always_comb
    begin
        case (timing_r.trigger_divider_sel)
            2'h0: div_last = `TRIGDIV_0;
            2'h1: div_last = `TRIGDIV_1;
            2'h2: div_last = `TRIGDIV_2;
            default: div_last = `TRIGDIV_3;
        endcase
    end

    always_comb
    begin
        div_cnt_nxt = div_cnt_r;
        pending_nxt = pending_r;
        start_nxt = 1'b0;
        if (!step.busy && !start_r)
        begin
            if (burst_mode)
            begin
                start_nxt = 1'b1;
            end
            else if (lowpwr_mode && pending_r)
            begin
                start_nxt = 1'b1;
                pending_nxt = 1'b0;
            end
        end
        // a new divided trigger wins over the consume
        if (!lowpwr_mode)
        begin
            div_cnt_nxt = 6'h00;
            pending_nxt = 1'b0;
        end
        else if (trig_edge)
        begin
            if (div_cnt_r >= div_last)
            begin
                div_cnt_nxt = 6'h00;
                pending_nxt = 1'b1;
            end
            else
            begin
                div_cnt_nxt = div_cnt_r + 6'h01;
            end
        end
        dac_enable_nxt = burst_mode | lowpwr_mode;
        settling_nxt = step.settling;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            div_cnt_r <= 6'h00;
            pending_r <= 1'b0;
            start_r <= 1'b0;
            dac_enable_r <= 1'b0;
            settling_r <= 1'b0;
        end
        else
        begin
            div_cnt_r <= div_cnt_nxt;
            pending_r <= pending_nxt;
            start_r <= start_nxt;
            dac_enable_r <= dac_enable_nxt;
            settling_r <= settling_nxt;
        end
    end

    // ------------------------------------------------------------
    // register bank and wishbone slave
    // ------------------------------------------------------------
    always_comb
    begin
        comparator_mode_sel_nxt = comparator_mode_sel_r;
        timing_nxt = timing_r;
        threshold_code_nxt = threshold_code_r;
        compare_result_bit_nxt = compare_result_bit_r;
        ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
        dat_nxt = 32'h00000000;
        if (step.done && (burst_mode || lowpwr_mode))
        begin
            compare_result_bit_nxt = sense_s2_r;
        end
        if (wr_en)
        begin
            case (wb_adr_i)
                `MODE_ADDR: comparator_mode_sel_nxt = wb_dat_i[`MODE_MSB:0];
                `TIMING_ADDR:
                begin
                    timing_nxt.trigger_divider_sel =
                        wb_dat_i[`TRIGDIV_MSB:`TRIGDIV_LSB];
                    timing_nxt.sample_delay_sel =
                        wb_dat_i[`SAMPLE_DELAY_SEL_MSB:`SAMPLE_DELAY_SEL_LSB];
                end
                `THRESH_ADDR:
                    threshold_code_nxt = wb_dat_i[`THRESH_MSB:0];
                default: comparator_mode_sel_nxt = comparator_mode_sel_r;
            endcase
        end
        if (ack_nxt && !wb_we_i)
        begin
            case (wb_adr_i)
                `MODE_ADDR: dat_nxt[`MODE_MSB:0] = comparator_mode_sel_r;
                `TIMING_ADDR:
                begin
                    dat_nxt[`TRIGDIV_MSB:`TRIGDIV_LSB] =
                        timing_r.trigger_divider_sel;
                    dat_nxt[`SAMPLE_DELAY_SEL_MSB:`SAMPLE_DELAY_SEL_LSB] =
                        timing_r.sample_delay_sel;
                end
                `THRESH_ADDR: dat_nxt[`THRESH_MSB:0] = threshold_code_r;
                `RESULT_ADDR: dat_nxt[7:0] = compare_result_bit_r;
                default: dat_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            comparator_mode_sel_r <= `MODE_RST;
            timing_r.trigger_divider_sel <=
                2'(`TIMING_RST >> `TRIGDIV_LSB);
            timing_r.sample_delay_sel <=
                3'(`TIMING_RST >> `SAMPLE_DELAY_SEL_LSB);
            threshold_code_r <= `THRESH_RST;
            compare_result_bit_r <= `RESULT_RST;
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end
        else
        begin
            comparator_mode_sel_r <= comparator_mode_sel_nxt;
            timing_r <= timing_nxt;
            threshold_code_r <= threshold_code_nxt;
            compare_result_bit_r <= compare_result_bit_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign dac_code = threshold_code_r;
    assign dac_enable = dac_enable_r;
    assign settling = settling_r;

endmodule

//--- cmp_cfg_monitor.sv
// checker for the comparator timing and threshold block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`include "cmp_cfg_map.svh"

module cmp_cfg_checker
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic timer_trigger_input,
    input wire logic [7:0] analog_sense_input,
    input wire logic [5:0] dac_code,
    input wire logic dac_enable,
    input wire logic settling
);
    import cmp_cfg_pkg::*;
    // ------------------------------------------------------------
    // request decode and properties
    // ------------------------------------------------------------
    wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic wr0 = take && wb_we_i && wb_sel_i[0];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_answer: assert property (take |=> wb_ack_o)
        else $error("request not acked next cycle");
    chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    chk_thresh_read: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i == `THRESH_ADDR
        |-> wb_dat_o == {26'h0, dac_code})
        else $error("threshold readback wrong");
    chk_thresh_drive: assert property (
        wr0 && wb_adr_i == `THRESH_ADDR
        |=> ##1 dac_code == $past(wb_dat_i[5:0], 2))
        else $error("dac code not threshold write");
    chk_mode_enable: assert property (
        wr0 && wb_adr_i == `MODE_ADDR
        |=> ##1 dac_enable == $past(wb_dat_i[1], 2))
        else $error("dac enable not following mode");
    chk_reset_clear: assert property (disable iff (1'b0)
        sys_rst |=> dac_code == 6'h00 && !dac_enable && !wb_ack_o)
        else $error("reset did not clear outputs");
    chk_settle_max: assert property (settling [*3] |=> !settling)
        else $error("settling longer than three");
    chk_step_gap: assert property (
        $rose(settling) |=> (!$rose(settling)) [*8])
        else $error("steps too close");
endmodule

bind comparator_timing_threshold_cfg cmp_cfg_checker i_cmp_cfg_checker
(
    .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .timer_trigger_input(timer_trigger_input),
    .analog_sense_input(analog_sense_input), .dac_code(dac_code),
    .dac_enable(dac_enable), .settling(settling)
);

//--- tb_comparator_timing_threshold_cfg.sv
// self-checking bench for the comparator timing and threshold block
// assumes the design and its checker are compiled before it
`timescale 1ns/1ps
`include "cmp_cfg_map.svh"

module tb_comparator_timing_threshold_cfg;
    import cmp_cfg_pkg::*;
    logic sys_clk, sys_rst = 1, cyc = 0, stb = 0, we = 0, trig = 0;
    logic [31:0] adr = 0, wdat = 0, rd, wb_dat_o, old_v, new_v;
    logic [3:0] sel = 0;
    logic [7:0] sense = 0;
    logic [5:0] dac_code;
    logic wb_ack_o, dac_enable, settling;
    logic [31:0] settle_tab [8] = '{32'h1, 32'h1, 32'h2, 32'h2,
        32'h2, 32'h2, 32'h3, 32'h3};
    int n_errors = 0, checks_done = 0, n;

    comparator_timing_threshold_cfg i_comparator_timing_threshold_cfg
    (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .timer_trigger_input(trig), .analog_sense_input(sense),
        .dac_code(dac_code), .dac_enable(dac_enable), .settling(settling)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task tally_and_finish;
        if (n_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task check_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task idle(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge sys_clk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= s;
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        cyc <= 0; stb <= 0; we <= 0;
    endtask
    task rd_chk(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, 4'hF);
        check_word(rd, exp);
    endtask
    task settle_len;
        do @(posedge sys_clk); while (settling !== 1'b0);
        do @(posedge sys_clk); while (settling !== 1'b1);
        n = 0;
        while (settling === 1'b1)
        begin
            n++;
            @(posedge sys_clk);
        end
    endtask
    task pulse;
        @(posedge sys_clk);
        trig <= 1;
        idle(3);
        trig <= 0;
        idle(2);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset_vals;
        rd_chk(`MODE_ADDR, 32'h0);
        rd_chk(`TIMING_ADDR, 32'h37);
        rd_chk(`THRESH_ADDR, 32'h0);
        xfer(1'b1, `THRESH_ADDR, 32'h2A, 4'hF);
        rd_chk(`THRESH_ADDR, 32'h2A);
        sys_rst <= 1;
        idle(3);
        sys_rst <= 0;
        rd_chk(`THRESH_ADDR, 32'h0);
        check_word({26'h0, dac_code}, 32'h0);
    endtask
    task t_thresh;
        xfer(1'b1, `THRESH_ADDR, 32'hFF, 4'hF);
        rd_chk(`THRESH_ADDR, 32'h3F);
        check_word({26'h0, dac_code}, 32'h3F);
        xfer(1'b1, `THRESH_ADDR, 32'h15, 4'hE);
        rd_chk(`THRESH_ADDR, 32'h3F);
        xfer(1'b1, `THRESH_ADDR, 32'h0, 4'h1);
        rd_chk(`THRESH_ADDR, 32'h0);
    endtask
    task t_map;
        xfer(1'b1, `TIMING_ADDR, 32'hFF, 4'hF);
        rd_chk(`TIMING_ADDR, 32'h37);
        xfer(1'b1, `RESULT_ADDR, 32'hFF, 4'hF);
        rd_chk(`RESULT_ADDR, 32'h0);
        xfer(1'b1, 32'h0003F50C, 32'hFF, 4'hF);
        rd_chk(32'h0003F50C, 32'h0);
    endtask
    task t_burst;
        @(posedge sys_clk);
        sense <= 8'hA5;
        xfer(1'b1, `MODE_ADDR, 32'h2, 4'hF);
        idle(2);
        check_word({31'h0, dac_enable}, 32'h1);
        for (int c = 0; c < 8; c++)
        begin
            xfer(1'b1, `TIMING_ADDR, c, 4'hF);
            settle_len();
            settle_len();
            check_word(n, settle_tab[c]);
        end
        rd_chk(`RESULT_ADDR, 32'hA5);
        sense <= 8'h5A;
        idle(150);
        rd_chk(`RESULT_ADDR, 32'h5A);
        xfer(1'b1, `MODE_ADDR, 32'h1, 4'hF);
        idle(2);
        check_word({31'h0, dac_enable}, 32'h0);
        sense <= 8'hFF;
        idle(150);
        rd_chk(`RESULT_ADDR, 32'h5A);
    endtask
    task t_lowpower(input int code);
        xfer(1'b1, `MODE_ADDR, 32'h0, 4'hF);
        xfer(1'b1, `TIMING_ADDR, (code << 4) | 7, 4'hF);
        xfer(1'b1, `MODE_ADDR, 32'h3, 4'hF);
        sense <= new_v[7:0];
        repeat ((8 << code) - 1) pulse();
        idle(90);
        rd_chk(`RESULT_ADDR, old_v);
        pulse();
        idle(90);
        rd_chk(`RESULT_ADDR, new_v);
        old_v = new_v;
        new_v = old_v ^ 32'hFF;
    endtask

    initial
    begin
        sys_clk = 0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (30000) @(posedge sys_clk);
        n_errors++;
        tally_and_finish();
    end
    initial
    begin
        idle(12);
        sys_rst <= 0;
        t_reset_vals();
        t_thresh();
        t_map();
        t_burst();
        old_v = 32'h5A;
        new_v = 32'h3C;
        for (int c = 0; c < 4; c++)
            t_lowpower(c);
        tally_and_finish();
    end
endmodule
